//--- wdrc_top.v
// watchdog timer and reset control with an apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "wdrc_consts.vh"
// How it works
// - watchdog overflow while running resets the device unless software clears it first
// - enable key 10101b stops the watchdog
// - enable key 01010b lets the watchdog count
// - any other key value causes a full reset after the delay
// - enable key powers up as the enable code
// - time-out while running resets the device and sets the time-out flag
// - time-out in sleep or idle sets the flag, clears only pc and sp
// - corruption, clear, halt or low reset pin clear the counter
// - power-on reset restarts the program counter at zero
// - power-on reset sets all port data and direction high
// - low reset pin, when selected, resets and restarts the pc at zero
// - after the pin is released an extra delay precedes running
// - select 01010101b gives shared i/o, 10101010b gives reset pin
// - any other select value resets the device after the delay
// - a select corruption reset sets the select corruption flag
// - the select register powers up holding the shared code
// - every reset but the warm time-out restores the select register
// - reset pin selection overrides other shared pin functions
// - select corruption flag is sticky, cleared by writing zero or by power-on reset
// - upper four bits of the reset flags read zero
// - period is the slow clock divided by 2^8 up to 2^18
// - key corruption reset sets a sticky flag that software or power-on reset clears
// - halt sets the power-down flag, power-up or clear clears it

module wdrc_top #(
    parameter SRESET_CYC = `WDRC_SRESET_CYC,
    parameter RSTD_CYC = `WDRC_RSTD_CYC,
    parameter CNT_W = 12
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire low_speed_internal_osc,
    input wire external_reset_pin_n,
    input wire clear_watchdog_instr,
    input wire halt_instr,
    input wire low_power_mode,
    output reg sys_reset,
    output reg pc_sp_clear,
    output reg ports_init_high,
    output reg reset_pin_override
);

    // reset sequencer states
    localparam ST_RUN = 2'd0;
    localparam ST_SWDLY = 2'd1;
    localparam ST_PINLOW = 2'd2;
    localparam ST_HOLD = 2'd3;

    reg [7:0] watchdog_control_reg;
    reg [7:0] reset_pin_select;
    reg resetsel_corrupt_flag;
    reg wdtcfg_corrupt_flag;
    reg timeout_flag;
    reg powerdown_flag;
    reg [17:0] wdt_count;
    reg [1:0] state;
    reg [CNT_W-1:0] delay_cnt;
    reg por_kind;
    reg key_bad_seen;
    reg sel_bad_seen;
    reg [2:0] osc_sync;
    reg osc_level;
    reg [2:0] pin_sync;
    reg pin_level;
    reg [17:0] term;
    wire [4:0] wdt_enable_key;
    wire [2:0] wdt_period_select;
    wire key_bad;
    wire sel_bad;
    wire wdt_run;
    wire osc_tick;
    wire pin_low;
    wire timeout;
    wire wr_en;
    wire rd_setup;
    wire mapped;

    assign wdt_enable_key = watchdog_control_reg[`WDRC_KEY_MSB:`WDRC_KEY_LSB];
    assign wdt_period_select =
        watchdog_control_reg[`WDRC_PER_MSB:`WDRC_PER_LSB];

    // protected register validity
    assign key_bad = (wdt_enable_key != `WDRC_KEY_ENABLE) &&
                     (wdt_enable_key != `WDRC_KEY_DISABLE);
    assign sel_bad = (reset_pin_select != `WDRC_SEL_SHARED) &&
                     (reset_pin_select != `WDRC_SEL_RESET_PIN);
    assign wdt_run = (wdt_enable_key == `WDRC_KEY_ENABLE);

    // pready stays high: every access ends in one access cycle
    // apb decode, zero wait states
    assign mapped = (paddr == `WDRC_OFF_WDT_CTRL) ||
                    (paddr == `WDRC_OFF_RST_SEL) ||
                    (paddr == `WDRC_OFF_RST_FLAGS) ||
                    (paddr == `WDRC_OFF_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped && !sys_reset;
    assign rd_setup = psel && !penable;

    // agreement of two stages rejects a level caught mid-change
    // three-stage synchronisers for the slow clock and reset pin
    always @(posedge clk)
    begin
        if (srst)
        begin
            osc_sync <= 3'h0;
            osc_level <= 1'b0;
            pin_sync <= 3'h7;
            pin_level <= 1'b1;
        end
        else
        begin
            osc_sync <= {osc_sync[1:0], low_speed_internal_osc};
            pin_sync <= {pin_sync[1:0], external_reset_pin_n};
            if (osc_sync[1] == osc_sync[2])
                osc_level <= osc_sync[2];
            if (pin_sync[1] == pin_sync[2])
                pin_level <= pin_sync[2];
        end
    end

    // the slow clock is far slower than clk, so no tick is lost
    // filtered rising edge of the slow clock, filtered low reset pin
    assign osc_tick = (osc_sync[1] == osc_sync[2]) && osc_sync[2] &&
                      !osc_level;
    assign pin_low = !pin_level &&
                     (reset_pin_select == `WDRC_SEL_RESET_PIN);

    // terminal count for the selected division ratio
    always @*
    begin
        case (wdt_period_select)
            3'd0: term = 18'h000ff;
            3'd1: term = 18'h003ff;
            3'd2: term = 18'h00fff;
            3'd3: term = 18'h03fff;
            3'd4: term = 18'h07fff;
            3'd5: term = 18'h0ffff;
            3'd6: term = 18'h1ffff;
            default: term = 18'h3ffff;
        endcase
    end

    assign timeout = (state == ST_RUN) && wdt_run && osc_tick &&
                     (wdt_count >= term);

    // clears win over counting, so a clear on a tick edge sticks
    // watchdog counter
    always @(posedge clk)
    begin
        if (srst)
            wdt_count <= 18'h0;
        else if (state != ST_RUN)
            wdt_count <= 18'h0;
        else if ((key_bad && !key_bad_seen) || clear_watchdog_instr ||
                 halt_instr || pin_low)
            wdt_count <= 18'h0;
        else if (timeout)
            wdt_count <= 18'h0;
        else if (wdt_run && osc_tick)
            wdt_count <= wdt_count + 18'h1;
    end

    // a low reset pin cuts any software or release delay short
    // reset sequencer: software delay, pin hold, release delay
    always @(posedge clk)
    begin
        if (srst)
        begin
            state <= ST_HOLD;
            delay_cnt <= {CNT_W{1'b0}};
            por_kind <= 1'b1;
            key_bad_seen <= 1'b0;
            sel_bad_seen <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    delay_cnt <= {CNT_W{1'b0}};
                    por_kind <= 1'b0;
                    if (pin_low)
                    begin
                        state <= ST_PINLOW;
                    end
                    else if (key_bad || sel_bad)
                    begin
                        state <= ST_SWDLY;
                        key_bad_seen <= key_bad;
                        sel_bad_seen <= sel_bad;
                    end
                    else if (timeout && !low_power_mode)
                    begin
                        state <= ST_HOLD;
                    end
                end
                ST_SWDLY:
                begin
                    if (pin_low)
                    begin
                        state <= ST_PINLOW;
                        delay_cnt <= {CNT_W{1'b0}};
                    end
                    else if (delay_cnt == SRESET_CYC[CNT_W-1:0] - 1'b1)
                    begin
                        state <= ST_HOLD;
                        delay_cnt <= {CNT_W{1'b0}};
                    end
                    else
                        delay_cnt <= delay_cnt + 1'b1;
                end
                ST_PINLOW:
                begin
                    delay_cnt <= {CNT_W{1'b0}};
                    if (pin_level)
                        state <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    key_bad_seen <= 1'b0;
                    sel_bad_seen <= 1'b0;
                    if (pin_low)
                        state <= ST_PINLOW;
                    else if (delay_cnt == RSTD_CYC[CNT_W-1:0] - 1'b1)
                    begin
                        state <= ST_RUN;
                        delay_cnt <= {CNT_W{1'b0}};
                    end
                    else
                        delay_cnt <= delay_cnt + 1'b1;
                end
                default:
                    state <= ST_HOLD;
            endcase
        end
    end

    // writes only land while running, never during a delay
    // protected registers, restored by all but the warm time-out reset
    always @(posedge clk)
    begin
        if (srst)
        begin
            watchdog_control_reg <= `WDRC_WDT_CTRL_POR;
            reset_pin_select <= `WDRC_SEL_SHARED;
        end
        else if (state == ST_SWDLY &&
                 delay_cnt == SRESET_CYC[CNT_W-1:0] - 1'b1)
        begin
            watchdog_control_reg <= `WDRC_WDT_CTRL_POR;
            reset_pin_select <= `WDRC_SEL_SHARED;
        end
        else if (state == ST_PINLOW && pin_level)
        begin
            watchdog_control_reg <= `WDRC_WDT_CTRL_POR;
            reset_pin_select <= `WDRC_SEL_SHARED;
        end
        else if (wr_en && state == ST_RUN)
        begin
            if (paddr == `WDRC_OFF_WDT_CTRL)
                watchdog_control_reg <= pwdata[7:0];
            if (paddr == `WDRC_OFF_RST_SEL)
                reset_pin_select <= pwdata[7:0];
        end
    end

    // sticky corruption flags, hardware set wins over a software clear
    always @(posedge clk)
    begin
        if (srst)
        begin
            resetsel_corrupt_flag <= 1'b0;
            wdtcfg_corrupt_flag <= 1'b0;
        end
        else
        begin
            if (state == ST_SWDLY &&
                delay_cnt == SRESET_CYC[CNT_W-1:0] - 1'b1 && sel_bad_seen)
                resetsel_corrupt_flag <= 1'b1;
            else if (wr_en && paddr == `WDRC_OFF_RST_FLAGS &&
                     !pwdata[`WDRC_FLAG_RSTSEL])
                resetsel_corrupt_flag <= 1'b0;
            if (state == ST_SWDLY &&
                delay_cnt == SRESET_CYC[CNT_W-1:0] - 1'b1 && key_bad_seen)
                wdtcfg_corrupt_flag <= 1'b1;
            else if (wr_en && paddr == `WDRC_OFF_RST_FLAGS &&
                     !pwdata[`WDRC_FLAG_WDTCFG])
                wdtcfg_corrupt_flag <= 1'b0;
        end
    end

    // a time-out on the same edge as a clear still sets the flag
    // time-out and power-down status bits
    always @(posedge clk)
    begin
        if (srst)
        begin
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
        end
        else
        begin
            if (timeout)
                timeout_flag <= 1'b1;
            else if (clear_watchdog_instr || halt_instr)
                timeout_flag <= 1'b0;
            if (halt_instr)
                powerdown_flag <= 1'b1;
            else if (clear_watchdog_instr)
                powerdown_flag <= 1'b0;
        end
    end

    // reset outputs towards the core and ports
    always @(posedge clk)
    begin
        if (srst)
        begin
            sys_reset <= 1'b1;
            pc_sp_clear <= 1'b0;
            ports_init_high <= 1'b1;
            reset_pin_override <= 1'b0;
        end
        else
        begin
            sys_reset <= (state == ST_PINLOW) || (state == ST_HOLD) ||
                         pin_low || (timeout && !low_power_mode);
            pc_sp_clear <= timeout && low_power_mode;
            ports_init_high <= por_kind && (state == ST_HOLD);
            reset_pin_override <= (reset_pin_select ==
                                   `WDRC_SEL_RESET_PIN);
        end
    end

    // loading in setup keeps read data on a flop for the access
    // read data captured in the setup phase
    always @(posedge clk)
    begin
        if (srst)
            prdata <= 32'h0;
        else if (rd_setup)
        begin
            case (paddr)
                `WDRC_OFF_WDT_CTRL: prdata <= {24'h0, watchdog_control_reg};
                `WDRC_OFF_RST_SEL: prdata <= {24'h0, reset_pin_select};
                `WDRC_OFF_RST_FLAGS:
                    prdata <= {28'h0, resetsel_corrupt_flag, 2'b00,
                               wdtcfg_corrupt_flag};
                `WDRC_OFF_STATUS:
                    prdata <= {30'h0, powerdown_flag, timeout_flag};
                default: prdata <= 32'h0;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- wdrc_consts.vh
// register offsets, codes, reset values and timing counts of the watchdog
`ifndef WDRC_CONSTS_VH
`define WDRC_CONSTS_VH

// register byte offsets on the bus
`define WDRC_OFF_WDT_CTRL 12'h000
`define WDRC_OFF_RST_SEL 12'h004
`define WDRC_OFF_RST_FLAGS 12'h008
`define WDRC_OFF_STATUS 12'h00c

// watchdog control: enable key field and period field
`define WDRC_KEY_MSB 7
`define WDRC_KEY_LSB 3
`define WDRC_PER_MSB 2
`define WDRC_PER_LSB 0
`define WDRC_KEY_DISABLE 5'h15
`define WDRC_KEY_ENABLE 5'h0a
`define WDRC_WDT_CTRL_POR 8'h53

// reset pin select codes
`define WDRC_SEL_SHARED 8'h55
`define WDRC_SEL_RESET_PIN 8'haa

// reset source flag bit positions
`define WDRC_FLAG_RSTSEL 3
`define WDRC_FLAG_LOWVOLT 2
`define WDRC_FLAG_LVCFG 1
`define WDRC_FLAG_WDTCFG 0

// status bit positions
`define WDRC_STAT_TIMEOUT 0
`define WDRC_STAT_POWERDOWN 1

// timing: clock period, delays in ns and derived cycle counts
`define WDRC_CLK_NS 50
`define WDRC_SRESET_NS 800
`define WDRC_RSTD_NS 1600
`define WDRC_SRESET_CYC ((`WDRC_SRESET_NS + `WDRC_CLK_NS - 1) / `WDRC_CLK_NS)
`define WDRC_RSTD_CYC ((`WDRC_RSTD_NS + `WDRC_CLK_NS - 1) / `WDRC_CLK_NS)

`endif

//--- wdrc_checker.sv
// concurrent checks on the watchdog and reset control ports
`timescale 1ns/1ps
`default_nettype none
module wdrc_checker #(
    parameter SRESET_CYC = 16,
    parameter RSTD_CYC = 32
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire external_reset_pin_n,
    input wire sys_reset,
    input wire pc_sp_clear,
    input wire ports_init_high,
    input wire reset_pin_override
);
    localparam int SR_LO = SRESET_CYC - 1;
    localparam int SR_HI = SRESET_CYC + 3;
    localparam int RH_LO = RSTD_CYC - 2;
    logic [7:0] hi_cnt;
    // accepted writes and the two kinds of corrupt value
    wire wr = psel && penable && pwrite && !sys_reset;
    wire bad_key = wr && paddr == 12'h000 && pwdata[7:3] != 5'h0a
        && pwdata[7:3] != 5'h15;
    wire bad_sel = wr && paddr == 12'h004 && pwdata[7:0] != 8'h55
        && pwdata[7:0] != 8'haa;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // length of the current reset hold, saturating
    always @(posedge clk)
        if (srst || !sys_reset)
            hi_cnt <= 8'h00;
        else if (hi_cnt != 8'hff)
            hi_cnt <= hi_cnt + 8'h01;
    a_por_state: assert property ($fell(srst) |->
        sys_reset && ports_init_high) else $error("bad state after reset");
    a_init_only: assert property (ports_init_high |-> sys_reset)
        else $error("ports held high outside reset");
    a_key_delay: assert property (bad_key |=> !sys_reset [*8])
        else $error("corrupt key reset came too early");
    a_key_reset: assert property (bad_key |-> ##[SR_LO:SR_HI] sys_reset)
        else $error("corrupt key did not reset");
    a_sel_reset: assert property (bad_sel |-> ##[SR_LO:SR_HI] sys_reset)
        else $error("corrupt select did not reset");
    a_pin_select: assert property (wr && paddr == 12'h004
        && pwdata[7:0] == 8'haa |-> ##[1:2] reset_pin_override)
        else $error("reset pin not selected");
    a_pin_reset: assert property (reset_pin_override
        && $fell(external_reset_pin_n) |-> ##[2:6] sys_reset)
        else $error("pin low did not reset");
    a_hold_len: assert property ($fell(sys_reset) |-> hi_cnt >= RH_LO)
        else $error("reset hold too short");
    a_sleep_pulse: assert property (pc_sp_clear |->
        !sys_reset ##1 !pc_sp_clear) else $error("bad sleep time-out");
    a_flags_upper: assert property (psel && penable && !pwrite
        && paddr == 12'h008 |-> prdata[31:4] == 28'h0)
        else $error("flag upper bits not zero");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h00c
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    c_sleep: cover property (pc_sp_clear);
    c_pin_hold: cover property ($fell(sys_reset) && hi_cnt > RH_LO + 8);
    c_key: cover property (bad_key);
endmodule
`default_nettype wire

//--- wdrc_partner.sv
// slow oscillator and pulled-up external reset line beside the block
`timescale 1ns/1ps
`default_nettype none
module wdrc_partner (
    input wire logic pull_low,
    output logic slow_osc,
    output logic reset_pin_n
);
    // free running slow clock, phase unrelated to clk
    initial
    begin
        slow_osc = 1'b0;
        #37;
        forever #205 slow_osc = ~slow_osc;
    end
    // pull-up holds the line high unless pulled low
    assign reset_pin_n = !pull_low;
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, srst, psel, penable, pwrite, clr, halt, lpm, pull_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, slow_osc, reset_pin_n, err;
    logic sys_reset, pc_sp_clear, ports_init_high, override;
    int num_errors = 0;
    int check_count = 0;
    int psc_seen = 0;
    int n;
    wdrc_top #(.SRESET_CYC(16), .RSTD_CYC(32)) wdrc_top_i (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_speed_internal_osc(slow_osc),
        .external_reset_pin_n(reset_pin_n), .clear_watchdog_instr(clr),
        .halt_instr(halt), .low_power_mode(lpm), .sys_reset(sys_reset),
        .pc_sp_clear(pc_sp_clear), .ports_init_high(ports_init_high),
        .reset_pin_override(override));
    wdrc_partner wdrc_partner_i (.pull_low(pull_low),
        .slow_osc(slow_osc), .reset_pin_n(reset_pin_n));
    // clock and a count of sleep time-out pulses
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (pc_sp_clear === 1'b1)
            psc_seen++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_sys(input logic lvl, input int lim);
        n = 0;
        while (sys_reset !== lvl && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, sys_reset}, {31'h0, lvl});
    endtask
    task automatic pulse_clr;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        #(50 * 40000);
        num_errors++;
        wrap_up;
    end
    // main sequence
    initial
    begin
        {srst, psel, penable, pwrite, clr, halt, lpm, pull_low} = 8'hff;
        {psel, penable, pwrite, clr, halt, lpm, pull_low} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd_chk(12'h000, 32'h53);
        rd_chk(12'h004, 32'h55);
        rd_chk(12'h008, 32'h0);
        rd_chk(12'h00c, 32'h0);
        check({31'h0, ports_init_high}, 32'h1);
        rd_chk(12'h010, 32'h0);
        check({31'h0, err}, 32'h1);
        wait_sys(1'b0, 100);
        $display("test power-on done");
        apb(1'b1, 12'h000, 32'ha8);
        repeat (2300) @(posedge clk);
        check({31'h0, sys_reset}, 32'h0);
        apb(1'b1, 12'h000, 32'h50);
        repeat (3)
        begin
            repeat (1500) @(posedge clk);
            pulse_clr;
        end
        check({31'h0, sys_reset}, 32'h0);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        rd_chk(12'h00c, 32'h2);
        pulse_clr;
        rd_chk(12'h00c, 32'h0);
        repeat (1880) @(posedge clk);
        check({31'h0, sys_reset}, 32'h0);
        wait_sys(1'b1, 600);
        wait_sys(1'b0, 200);
        rd_chk(12'h00c, 32'h1);
        rd_chk(12'h000, 32'h50);
        $display("test running time-out done");
        lpm <= 1'b1;
        pulse_clr;
        psc_seen = 0;
        n = 0;
        while (psc_seen == 0 && n < 2600)
        begin
            @(posedge clk);
            n++;
        end
        check(psc_seen, 1);
        check({31'h0, sys_reset}, 32'h0);
        rd_chk(12'h00c, 32'h1);
        apb(1'b1, 12'h000, 32'ha8);
        lpm <= 1'b0;
        $display("test sleep time-out done");
        apb(1'b1, 12'h000, 32'h00);
        wait_sys(1'b1, 40);
        wait_sys(1'b0, 100);
        rd_chk(12'h000, 32'h53);
        apb(1'b1, 12'h008, 32'hff);
        rd_chk(12'h008, 32'h1);
        apb(1'b1, 12'h008, 32'h0);
        rd_chk(12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h12);
        wait_sys(1'b1, 40);
        wait_sys(1'b0, 100);
        rd_chk(12'h004, 32'h55);
        rd_chk(12'h008, 32'h8);
        apb(1'b1, 12'h008, 32'h08);
        rd_chk(12'h008, 32'h8);
        apb(1'b1, 12'h008, 32'h0);
        rd_chk(12'h008, 32'h0);
        apb(1'b1, 12'h000, 32'ha8);
        $display("test corruption done");
        pull_low <= 1'b1;
        repeat (10) @(posedge clk);
        check({31'h0, sys_reset}, 32'h0);
        pull_low <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h004, 32'haa);
        repeat (2) @(posedge clk);
        check({31'h0, override}, 32'h1);
        pull_low <= 1'b1;
        wait_sys(1'b1, 10);
        repeat (20) @(posedge clk);
        pull_low <= 1'b0;
        wait_sys(1'b0, 60);
        check(n >= 32 && n <= 40, 1);
        rd_chk(12'h004, 32'h55);
        check({31'h0, override}, 32'h0);
        $display("test reset pin done");
        wrap_up;
    end
endmodule
bind wdrc_top wdrc_checker #(.SRESET_CYC(SRESET_CYC), .RSTD_CYC(RSTD_CYC))
    wdrc_checker_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .external_reset_pin_n(external_reset_pin_n),
    .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear),
    .ports_init_high(ports_init_high),
    .reset_pin_override(reset_pin_override));
`default_nettype wire
